// ### rtl/host_port_pkg.sv
package host_port_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL_A   = 12'h000;
    localparam logic [11:0] OFS_CTRL_B   = 12'h004;
    localparam logic [11:0] OFS_IPC      = 12'h008;
    localparam logic [11:0] OFS_STAT_A   = 12'h00C;
    localparam logic [11:0] OFS_STAT_B   = 12'h010;
    localparam logic [11:0] OFS_PORTSTAT = 12'h014;
    localparam logic [11:0] OFS_GLOBAL   = 12'h018;
    localparam logic [11:0] OFS_VECTOR   = 12'h01C;
    localparam logic [11:0] OFS_LEVEL_A  = 12'h020;
    localparam logic [11:0] OFS_LEVEL_B  = 12'h024;
    localparam logic [11:0] CHAN_STRIDE  = 12'h040;

    // ---------------------------------------------------------------
    // Control fields
    // ---------------------------------------------------------------
    localparam int CTRL_DMA_BIT    = 7;
    localparam int CTRL_MODE_LSB   = 8;
    localparam int CTRL_THR_LSB    = 0;
    localparam int IPC_DAISY_BIT   = 0;
    localparam int IPC_PUSHPULL    = 1;
    localparam int IPC_VEC_LSB     = 8;
    localparam int SILICON_REV_ONE = 1;

    // ---------------------------------------------------------------
    // Reset values and sizes
    // ---------------------------------------------------------------
    localparam logic [5:0] HALF_BYTES  = 6'h20;
    localparam logic [5:0] THR_RESET   = 6'h20;
    localparam logic [5:0] THR_MIN_ASY = 6'h01;
    localparam logic [5:0] THR_MIN_HDL = 6'h02;
    localparam logic [7:0] VEC_RESET   = 8'h00;

    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_BISYNC,
        MODE_HDLC
    } serial_mode_e;

    typedef enum logic [1:0] {
        ACC_WORD,
        ACC_UPPER,
        ACC_LOWER,
        ACC_NONE
    } lane_access_e;

endpackage

// ### rtl/dual_channel_host_bus_port.sv
// Function
// RULE1: Daisy mode selected in port config uses chain enable out and in.
// RULE2: Highest priority device has chain enable input tied high externally.
// RULE3: Two-pulse mode: two-cycle acknowledge; chain settles before second pulse.
// RULE4: Single-pulse mode: chain settles before data strobe falls.
// RULE5: Each channel has 64-byte receive and transmit pools, two 32-byte halves.
// RULE6: Only one half of each pool faces the host at a time.
// RULE7: Width strap high permits word accesses; byte accesses still allowed.
// RULE8: Receive threshold resets to 32, down to 1 (async/bisync) or 2 (HDLC).
// RULE9: First silicon fixes HDLC receive threshold at 32 bytes.
// RULE10: First silicon host must not mix byte and word on one half.
// RULE11: Later parts: continue-only transmit needs a full 32-byte half first.
// RULE12: No fill restriction when message end accompanies transmit command.
// RULE13: Upper enable and address bit zero select word, upper, lower, or none.
// RULE14: Two-pulse: odd address on upper lanes; single-pulse reversed.
// RULE15: Each channel has an identical independent register set.
// RULE16: Common interrupt and port registers reachable through either channel set.
// RULE17: After reset each channel uses interrupt-driven transfer.
// RULE18: DMA bit in byte count high register switches channel to DMA.
// RULE19: Four DMA request lines: transmit and receive per channel.
// RULE20: One interrupt output, open-drain or push-pull by port config.
// RULE21: Vector given in acknowledge; status registers also readable.
// RULE22: Daisy mode accepts acknowledge only while chain enable input active.
// RULE23: Chain enable out follows in, forced low while own request active.
// RULE24: Reading status clears bits and global bit; irq drops when none remain.
// RULE25: Narrow strap makes every access a single byte on low lanes.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module dual_channel_host_bus_port #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic              wideBusStrap,
    input  wire logic              twoPulseMode,
    input  wire logic              upper_byte_enable_n,
    input  wire logic [3:0]        channelEvents,
    input  wire logic              portEvent,
    input  wire logic [3:0]        poolReady,
    input  wire logic              irq_acknowledge_n,
    input  wire logic              chain_enable_in,
    output logic                   chain_enable_out,
    output logic                   irqOut,
    output logic                   irqOe,
    output logic [7:0]             ackVector,
    output logic                   ackVectorValid,
    output logic [3:0]             dmaRequest,
    output logic [1:0]             hostHalf,
    output logic [5:0]             rxThresholdA,
    output logic [5:0]             rxThresholdB,
    output logic [1:0]             laneSelect
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] pinMeta_r;
    logic [5:0] pinSync_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_r <= 6'h3D;
            pinSync_r <= 6'h3D;
        end else begin
            pinMeta_r <= {upper_byte_enable_n, irq_acknowledge_n, chain_enable_in,
                          twoPulseMode, wideBusStrap, 1'b1};
            pinSync_r <= pinMeta_r;
        end
    end
    logic ubeN;
    logic ackN;
    logic chainIn;
    logic twoPulse;
    logic wideBus;
    assign ubeN     = pinSync_r[5];
    assign ackN     = pinSync_r[4];
    assign chainIn  = pinSync_r[3];
    assign twoPulse = pinSync_r[2];
    assign wideBus  = pinSync_r[1];

    // ---------------------------------------------------------------
    // Lane decode
    // ---------------------------------------------------------------
    host_port_pkg::lane_access_e laneAcc;
    always_comb begin
        if (!wideBus) begin
            laneAcc = host_port_pkg::ACC_LOWER;                    // [RULE25]
        end else if (!ubeN && !paddr[0]) begin
            laneAcc = host_port_pkg::ACC_WORD;                     // [RULE7] [RULE13]
        end else if (!ubeN) begin
            laneAcc = host_port_pkg::ACC_UPPER;                    // [RULE13]
        end else if (!paddr[0]) begin
            laneAcc = host_port_pkg::ACC_LOWER;                    // [RULE13]
        end else begin
            laneAcc = host_port_pkg::ACC_NONE;                     // [RULE13]
        end
    end
    assign laneSelect = laneAcc;

    // ---------------------------------------------------------------
    // APB decode; the whole register map repeats one stride above, so both windows reach the A and B registers
    // ---------------------------------------------------------------
    logic          chanB;
    logic [11:0]   regOfs;
    logic          access;
    logic          known;
    assign chanB  = (paddr[11:0] >= host_port_pkg::CHAN_STRIDE);   // [RULE15]
    assign regOfs = chanB ? paddr[11:0] - host_port_pkg::CHAN_STRIDE : paddr[11:0];
    assign access = psel && penable;
    assign pready = 1'b1;
    always_comb begin
        if (regOfs == host_port_pkg::OFS_CTRL_A || regOfs == host_port_pkg::OFS_CTRL_B ||
            regOfs == host_port_pkg::OFS_IPC || regOfs == host_port_pkg::OFS_STAT_A ||
            regOfs == host_port_pkg::OFS_STAT_B || regOfs == host_port_pkg::OFS_PORTSTAT ||
            regOfs == host_port_pkg::OFS_GLOBAL || regOfs == host_port_pkg::OFS_VECTOR ||
            regOfs == host_port_pkg::OFS_LEVEL_A || regOfs == host_port_pkg::OFS_LEVEL_B) begin
            known = (paddr[11:0] < 2 * host_port_pkg::CHAN_STRIDE);
        end else begin
            known = 1'b0;
        end
    end
    assign pslverr = access && !known;

    // ---------------------------------------------------------------
    // Per channel control: DMA bit, serial mode, threshold
    // ---------------------------------------------------------------
    logic [1:0]  dmaMode_r;
    logic [3:0]  serMode_r;
    logic [11:0] thrReq_r;
    logic [7:0]  ipc_r;
    logic [7:0]  vecBase_r;
    logic        wrOk;
    assign wrOk = access && pwrite && known;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmaMode_r <= 2'h0;                                     // [RULE17]
            serMode_r <= 4'h0;
            thrReq_r  <= {host_port_pkg::THR_RESET, host_port_pkg::THR_RESET}; // [RULE8]
        end else if (wrOk && regOfs == host_port_pkg::OFS_CTRL_A) begin
            dmaMode_r[0]  <= pwdata[host_port_pkg::CTRL_DMA_BIT];  // [RULE18]
            serMode_r[1:0] <= pwdata[host_port_pkg::CTRL_MODE_LSB +: 2];
            thrReq_r[5:0] <= pwdata[host_port_pkg::CTRL_THR_LSB +: 6];
        end else if (wrOk && regOfs == host_port_pkg::OFS_CTRL_B) begin
            dmaMode_r[1]   <= pwdata[host_port_pkg::CTRL_DMA_BIT]; // [RULE18]
            serMode_r[3:2] <= pwdata[host_port_pkg::CTRL_MODE_LSB +: 2];
            thrReq_r[11:6] <= pwdata[host_port_pkg::CTRL_THR_LSB +: 6];
        end
    end

    // Common config reachable from either channel window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ipc_r     <= 8'h00;
            vecBase_r <= host_port_pkg::VEC_RESET;
        end else if (wrOk && regOfs == host_port_pkg::OFS_IPC) begin // [RULE16]
            ipc_r     <= pwdata[7:0];
            vecBase_r <= pwdata[host_port_pkg::IPC_VEC_LSB +: 8];
        end
    end

    function automatic logic [5:0] clampThr(input logic [5:0] req, input logic [1:0] md);
        logic [5:0] lo;
        lo = (md == 2'(host_port_pkg::MODE_HDLC)) ? host_port_pkg::THR_MIN_HDL
                                                   : host_port_pkg::THR_MIN_ASY;
        if (md == 2'(host_port_pkg::MODE_HDLC) && host_port_pkg::SILICON_REV_ONE == 1) begin
            clampThr = host_port_pkg::HALF_BYTES;                  // [RULE9]
        end else if (req > host_port_pkg::HALF_BYTES || req == 6'h00) begin
            clampThr = host_port_pkg::HALF_BYTES;
        end else if (req < lo) begin
            clampThr = lo;                                         // [RULE8]
        end else begin
            clampThr = req;
        end
    endfunction
    assign rxThresholdA = clampThr(thrReq_r[5:0], serMode_r[1:0]);
    assign rxThresholdB = clampThr(thrReq_r[11:6], serMode_r[3:2]);

    // ---------------------------------------------------------------
    // Pool halves: a half swaps when the serial side hands it over
    // ---------------------------------------------------------------
    logic [1:0] hostHalf_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hostHalf_r <= 2'h0;
        end else begin
            // Handover checks no fill count, so message-end sends need no full half
            hostHalf_r <= hostHalf_r ^ {poolReady[2], poolReady[0]}; // [RULE5] [RULE6] [RULE12]
        end
    end
    assign hostHalf = hostHalf_r;

    // DMA requests: rxA, txA, rxB, txB; only in DMA mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmaRequest <= 4'h0;
        end else begin
            dmaRequest <= poolReady & {{2{dmaMode_r[1]}}, {2{dmaMode_r[0]}}}; // [RULE19]
        end
    end

    // ---------------------------------------------------------------
    // Sticky status; events in interrupt mode only for pool events
    // ---------------------------------------------------------------
    logic [3:0] statA_r;
    logic [3:0] statB_r;
    logic       portStat_r;
    logic       rdStatA;
    logic       rdStatB;
    logic       rdPort;
    assign rdStatA = access && !pwrite && regOfs == host_port_pkg::OFS_STAT_A;
    assign rdStatB = access && !pwrite && regOfs == host_port_pkg::OFS_STAT_B;
    assign rdPort  = access && !pwrite && regOfs == host_port_pkg::OFS_PORTSTAT;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statA_r    <= 4'h0;
            statB_r    <= 4'h0;
            portStat_r <= 1'b0;
        end else begin
            // New events win over a clearing read
            statA_r    <= (rdStatA ? 4'h0 : statA_r) | {channelEvents[1:0], 2'h0} |
                          {2'h0, poolReady[1:0] & {2{!dmaMode_r[0]}}}; // [RULE24] [RULE17]
            statB_r    <= (rdStatB ? 4'h0 : statB_r) | {channelEvents[3:2], 2'h0} |
                          {2'h0, poolReady[3:2] & {2{!dmaMode_r[1]}}}; // [RULE24]
            portStat_r <= (rdPort ? 1'b0 : portStat_r) | portEvent;
        end
    end
    logic [2:0] globalStat;
    assign globalStat = {portStat_r, |statB_r, |statA_r};
    logic ownReq;
    assign ownReq = |globalStat;

    // ---------------------------------------------------------------
    // Interrupt output and daisy chain
    // ---------------------------------------------------------------
    logic daisy;
    logic inAck;
    assign daisy = ipc_r[host_port_pkg::IPC_DAISY_BIT];            // [RULE1]
    assign inAck = !ackN;
    // Request frozen at its last value during acknowledge in daisy mode so the chain stays settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqOut <= 1'b0;
        end else if (!inAck || !daisy) begin
            irqOut <= ownReq && (!daisy || chainIn);               // [RULE24] [RULE2]
        end
    end
    // Push-pull drives always; open-drain only pulls while asserted
    assign irqOe = ipc_r[host_port_pkg::IPC_PUSHPULL] ? 1'b1 : irqOut; // [RULE20]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_enable_out <= 1'b0;
        end else begin
            chain_enable_out <= daisy ? (chainIn && !ownReq) : chainIn; // [RULE23] [RULE1]
        end
    end

    // Acknowledge: two-pulse mode gives vector on the second pulse
    logic ackPrev_r;
    logic pulseCnt_r;
    logic ackFall;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackPrev_r <= 1'b0;
        end else begin
            ackPrev_r <= inAck;
        end
    end
    assign ackFall = inAck && !ackPrev_r;
    logic ackOk;
    assign ackOk = ackFall && (!daisy || chainIn) && ownReq;       // [RULE22] [RULE4]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_r <= 1'b0;
        end else if (ackOk && twoPulse) begin
            pulseCnt_r <= !pulseCnt_r;                             // [RULE3]
        end
    end
    logic [7:0] vector;
    always_comb begin
        if (|statA_r) begin
            vector = {vecBase_r[7:3], 3'h1};
        end else if (|statB_r) begin
            vector = {vecBase_r[7:3], 3'h2};
        end else begin
            vector = {vecBase_r[7:3], 3'h3};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackVector      <= 8'h00;
            ackVectorValid <= 1'b0;
        end else begin
            ackVectorValid <= ackOk && (!twoPulse || pulseCnt_r);  // [RULE21] [RULE3]
            if (ackOk) begin
                ackVector <= vector;                               // [RULE21]
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data with lane steering
    // ---------------------------------------------------------------
    logic [15:0] rawWord;
    always_comb begin
        if (regOfs == host_port_pkg::OFS_CTRL_A) begin
            rawWord = {6'h00, serMode_r[1:0], dmaMode_r[0], 1'b0, thrReq_r[5:0]};
        end else if (regOfs == host_port_pkg::OFS_CTRL_B) begin
            rawWord = {6'h00, serMode_r[3:2], dmaMode_r[1], 1'b0, thrReq_r[11:6]};
        end else if (regOfs == host_port_pkg::OFS_IPC) begin
            rawWord = {vecBase_r, ipc_r};
        end else if (regOfs == host_port_pkg::OFS_STAT_A) begin
            rawWord = {12'h000, statA_r};
        end else if (regOfs == host_port_pkg::OFS_STAT_B) begin
            rawWord = {12'h000, statB_r};
        end else if (regOfs == host_port_pkg::OFS_PORTSTAT) begin
            rawWord = {15'h0000, portStat_r};
        end else if (regOfs == host_port_pkg::OFS_GLOBAL) begin
            rawWord = {4'h0, hostHalf_r, 1'b0, irqOut, 5'h00, globalStat};
        end else if (regOfs == host_port_pkg::OFS_VECTOR) begin
            rawWord = {8'h00, vector};
        end else if (regOfs == host_port_pkg::OFS_LEVEL_A) begin
            rawWord = {10'h000, rxThresholdA};
        end else if (regOfs == host_port_pkg::OFS_LEVEL_B) begin
            rawWord = {10'h000, rxThresholdB};
        end else begin
            rawWord = 16'h0000;
        end
    end
    // Word register: two-pulse puts the odd byte high, single-pulse swaps
    logic [15:0] laneWord;
    always_comb begin
        if (laneAcc == host_port_pkg::ACC_WORD) begin
            laneWord = twoPulse ? rawWord : {rawWord[7:0], rawWord[15:8]}; // [RULE14]
        end else if (laneAcc == host_port_pkg::ACC_UPPER) begin
            laneWord = {rawWord[7:0], 8'h00};                      // [RULE13]
        end else if (laneAcc == host_port_pkg::ACC_LOWER) begin
            laneWord = {8'h00, rawWord[7:0]};                      // [RULE25]
        end else begin
            laneWord = 16'h0000;
        end
    end
    assign prdata = (access && !pwrite && known) ? {16'h0000, laneWord} : 32'h0000_0000;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_chain_forced_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE23]
        daisy && ownReq |=> !chain_enable_out)
        else $error("chain enable out high while own request");
    a_dma_reset_off: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
        $rose(rst_n) |-> dmaMode_r == 2'h0)
        else $error("dma mode not cleared");
    a_dma_gate: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
        !dmaMode_r[0] |=> !dmaRequest[0] || $past(dmaMode_r[0]))
        else $error("dma request in interrupt mode");
    a_narrow_lane: assert property (@(posedge clk) disable iff (!rst_n) // [RULE25]
        !wideBus |-> laneAcc == host_port_pkg::ACC_LOWER)
        else $error("narrow bus not single low byte");
    a_none_xfer: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        wideBus && ubeN && paddr[0] |-> laneWord == 16'h0000)
        else $error("transfer with both enables high");
    a_thr_bounds: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        rxThresholdA <= host_port_pkg::HALF_BYTES && rxThresholdA != 6'h00)
        else $error("threshold out of range");
    a_hdlc_fixed: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        serMode_r[1:0] == 2'(host_port_pkg::MODE_HDLC) |-> rxThresholdA == 6'h20)
        else $error("hdlc threshold not fixed");
    a_read_clears: assert property (@(posedge clk) disable iff (!rst_n) // [RULE24]
        rdStatA && channelEvents[1:0] == 2'h0 && poolReady[1:0] == 2'h0 |=> statA_r == 4'h0)
        else $error("status read did not clear");
    a_ack_gated: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
        daisy && !chainIn |=> !ackVectorValid)
        else $error("acknowledge accepted without chain enable");

endmodule

// ### bench/ack_host_model.sv
`timescale 1ns/100ps

module ack_host_model (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic twoPulse,
    output logic      irq_acknowledge_n
);
    initial irq_acknowledge_n = 1'b1;
    // Chain gets four cycles to settle before each pulse starts
    always @(posedge go) begin
        repeat (4) @(posedge clk);
        irq_acknowledge_n <= 1'b0;
        repeat (4) @(posedge clk);
        irq_acknowledge_n <= 1'b1;
        if (twoPulse) begin
            repeat (4) @(posedge clk);
            irq_acknowledge_n <= 1'b0;
            repeat (4) @(posedge clk);
            irq_acknowledge_n <= 1'b1;
        end
    end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ackGo;
    logic        wideBusStrap, twoPulseMode, upper_byte_enable_n, portEvent;
    logic        irq_acknowledge_n, chain_enable_in, chain_enable_out;
    logic        irqOut, irqOe, ackVectorValid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  channelEvents, poolReady, dmaRequest;
    logic [7:0]  ackVector;
    logic [1:0]  hostHalf, laneSelect;
    logic [5:0]  rxThresholdA, rxThresholdB, thr;
    logic [5:0]  thrExp [2];
    logic [1:0]  mode;
    logic        dma, ch;
    logic [1:0]  halfExp;
    logic [11:0] ctlAdr;
    int          fails, cmp_count, cycles, validCnt, v, b;
    int          dmaCnt [4];
    integer      seed;

    dual_channel_host_bus_port i_dual_channel_host_bus_port (.clk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .wideBusStrap, .twoPulseMode,
        .upper_byte_enable_n, .channelEvents, .portEvent, .poolReady, .irq_acknowledge_n,
        .chain_enable_in, .chain_enable_out, .irqOut, .irqOe, .ackVector, .ackVectorValid,
        .dmaRequest, .hostHalf, .rxThresholdA, .rxThresholdB, .laneSelect);
    ack_host_model i_ack_host_model (.clk, .go(ackGo), .twoPulse(twoPulseMode),
        .irq_acknowledge_n);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (ackVectorValid === 1'b1) validCnt++;
        for (int i = 0; i < 4; i++) if (dmaRequest[i] === 1'b1) dmaCnt[i]++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // HDLC threshold is fixed at a full half on first silicon
    function automatic logic [5:0] expThr(input logic [5:0] t, input logic [1:0] m);
        return (m == 2'h2) ? 6'h20 : t;
    endfunction

    // Lower-byte accesses only: no lane mixing on a pool, no transmit command
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // Registered effects of the access are only visible one edge later
        @(posedge clk);
    endtask

    task automatic pulse(input logic [3:0] ev, input logic [3:0] pr);
        channelEvents <= ev; poolReady <= pr;
        @(posedge clk);
        channelEvents <= 4'h0; poolReady <= 4'h0;
        repeat (5) @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 32'h310D1D0F;
        {rst_n, psel, penable, pwrite, paddr, pwdata, twoPulseMode, portEvent} = '0;
        {channelEvents, poolReady, ackGo, halfExp} = '0;
        {wideBusStrap, upper_byte_enable_n, chain_enable_in} = 3'h7;
        thrExp = '{6'h20, 6'h20};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(rxThresholdA, 32'h20);
        chk(rxThresholdB, 32'h20);
        apb(1'b0, host_port_pkg::OFS_CTRL_B, 32'h0);
        chk(rd[7], 32'h0);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            thr = 6'(($unsigned($random(seed)) % 32) + 1);
            mode = 2'(($unsigned($random(seed)) % 3));
            {dma, ch} = 2'($random(seed));
            if (i == 0) {thr, mode} = {6'h01, 2'h0};
            if (i == 1) {thr, mode} = {6'h02, 2'h2};
            ctlAdr = ch ? host_port_pkg::OFS_CTRL_B + host_port_pkg::CHAN_STRIDE
                        : host_port_pkg::OFS_CTRL_A;
            apb(1'b1, ctlAdr, {22'h0, mode, dma, 1'b0, thr});
            thrExp[ch] = expThr(thr, mode);
            chk(rxThresholdA, thrExp[0]);
            chk(rxThresholdB, thrExp[1]);
            apb(1'b0, ctlAdr, 32'h0);
            chk(rd[7], dma);
            b = dmaCnt[2 * ch];
            pulse(4'h0, 4'(1 << (2 * ch)));
            chk(dmaCnt[2 * ch] - b, dma);
            halfExp[ch] = !halfExp[ch];
            chk(hostHalf, halfExp);
        end
        apb(1'b0, 12'h03C, 32'h0);
        chk(err, 1'b1);
        $display("register test done");
        for (int k = 0; k < 8; k++) begin
            {wideBusStrap, upper_byte_enable_n} <= 2'(k >> 1);
            paddr <= 12'(k & 1);
            repeat (4) @(posedge clk);
            chk(laneSelect, (k < 4) ? 2'h2 : 2'(k & 3));
        end
        {wideBusStrap, upper_byte_enable_n} <= 2'h3;
        $display("lane test done");
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, host_port_pkg::OFS_IPC, 32'(2 - 2 * p));
            portEvent <= (p == 1);
            @(posedge clk);
            portEvent <= 1'b0;
            pulse(4'h1, 4'h0);
            chk(irqOut, 1'b1);
            chk(irqOe, 1'b1);
            apb(1'b0, host_port_pkg::OFS_GLOBAL + 12'h040, 32'h0);
            chk(|rd, 1'b1);
            chk(rd[2], 32'(p));
            for (int r = 0; r < 3; r++) begin
                apb(1'b0, host_port_pkg::OFS_STAT_A + 12'(4 * r), 32'h0);
            end
            repeat (3) @(posedge clk);
            chk(irqOut, 1'b0);
            chk(irqOe, 32'(1 - p));
        end
        $display("interrupt test done");
        apb(1'b1, host_port_pkg::OFS_IPC, 32'h5003);
        repeat (4) @(posedge clk);
        chk(chain_enable_out, 1'b1);
        pulse(4'h4, 4'h0);
        chk(chain_enable_out, 1'b0);
        for (int q = 0; q < 3; q++) begin
            twoPulseMode <= (q == 1);
            chain_enable_in <= (q < 2);
            repeat (4) @(posedge clk);
            v = validCnt;
            ackGo <= 1'b1;
            @(posedge clk);
            ackGo <= 1'b0;
            repeat (30) @(posedge clk);
            chk(validCnt - v, 32'(q < 2));
            chk(ackVector[7:3], 32'h0A);
        end
        $display("daisy chain test done");
        print_verdict();
    end
endmodule
